// ### logic/mode_map_decoder.sv
// Operating mode latch, on-chip memory decode, expansion bus pins and boot download engine.
// Assumes a CPU issuing one access per cycle and a serial receiver handing over whole bytes.
`timescale 1ns/1ps
`include "mode_map_defines.svh"
// Function
// - Mode pins are caught at reset release and pick one of four modes.
// - Single chip mode gives no external bus; ports B, C, F, direction stay GPIO.
// - Expanded mode reaches 64 KB: on-chip resources plus external space.
// - Expanded mode drives high address on B, low address on F, data on C.
// - Shared direction pin shows transfer direction; externals obey it.
// - Bootstrap enables boot ROM at BE40 to BFFF and runs the loader there.
// - Normal modes keep the boot ROM out of the map.
// - Loader stores up to 1024 bytes into RAM from 0080 in order.
// - Every received download byte is echoed on the transmitter.
// - Download ends after the sync byte's idle timeout (four character times for FF) or 1024 bytes, then jumps to 0080.
// - Port D runs open-drain while the loader runs.
// - Bootstrap mode fetches interrupt vectors from RAM.
// - Sync byte value picks baud rate and timeout; F0 and FD are extra rates.
// - Register block at page 0 after reset, movable to any 4 KB page.
// - Shared page puts RAM at x080, top part through x47F; else RAM at x000.
// - Map position register holds RAM page and register page nibbles.
// - EEPROM at xD80 when enabled; its page comes from a second register.
// - Test mode forces the ROM enable off.
// - Single chip forces ROM placement high, ROM at 8000 to FFFF.
// - Expanded with placement zero puts ROM at 0000 to 7FFF.
// - Main ROM decodes only while the ROM enable reads one.
module mode_map_decoder import mode_map_pkg::*; #(
  parameter int LOAD_MAX = 1024
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic rom_enable_bit_i,
  input wire logic rom_placement_bit_i,
  input wire logic eeprom_enable_i,
  input wire logic map_pos_wr_i,
  input wire logic [7:0] map_pos_i,
  input wire logic eeprom_pos_wr_i,
  input wire logic [3:0] eeprom_pos_i,
  input wire logic cpu_valid_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_rw_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] ext_rdata_o,
  output logic sel_reg_o,
  output logic sel_ram_o,
  output logic [9:0] ram_index_o,
  output logic sel_eeprom_o,
  output logic sel_boot_o,
  output logic sel_rom_o,
  output logic sel_ext_o,
  output logic [3:0] mode_o,
  output logic vector_from_ram_o,
  output logic portd_open_drain_o,
  input wire logic [7:0] gpio_b_i,
  input wire logic [7:0] gpio_b_oe_n_i,
  input wire logic [7:0] gpio_f_i,
  input wire logic [7:0] gpio_f_oe_n_i,
  input wire logic [7:0] gpio_c_i,
  input wire logic [7:0] gpio_c_oe_n_i,
  input wire logic gpio_dir_i,
  input wire logic gpio_dir_oe_n_i,
  output logic [7:0] port_b_o,
  output logic [7:0] port_b_oe_n_o,
  output logic [7:0] port_f_o,
  output logic [7:0] port_f_oe_n_o,
  input wire logic [7:0] port_c_i,
  output logic [7:0] port_c_o,
  output logic [7:0] port_c_oe_n_o,
  output logic shared_direction_pin_o,
  output logic shared_direction_pin_oe_n_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic char_tenth_tick_i,
  output logic [1:0] baud_sel_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic load_wr_o,
  output logic [15:0] load_addr_o,
  output logic [7:0] load_data_o,
  output logic jump_valid_o,
  output logic [15:0] jump_addr_o
);
  function automatic mode_t mode_from_pins(input logic b, input logic a);
    unique case ({b, a})
      `STRAP_BOOT: return MODE_BOOT;
      `STRAP_TEST: return MODE_TEST;
      `STRAP_SINGLE: return MODE_SINGLE;
      default: return MODE_EXPANDED;
    endcase
  endfunction
  function automatic logic on_page(input logic [15:0] addr, input logic [3:0] page);
    return addr[15:12] == page;
  endfunction
  mode_t mode, next_mode;
  logic captured, next_captured;
  logic [7:0] map_pos, next_map_pos;
  logic [3:0] ee_pos, next_ee_pos;
  // The strap is taken on the first edge after release, never under the reset itself.
  always_comb begin
    next_mode = captured ? mode : mode_from_pins(mode_pin_b_i, mode_pin_a_i);
    next_captured = 1'b1;
    next_map_pos = map_pos_wr_i ? map_pos_i : map_pos;
    next_ee_pos = eeprom_pos_wr_i ? eeprom_pos_i : ee_pos;
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode <= MODE_SINGLE;
      captured <= 1'b0;
      map_pos <= `MAP_POS_RESET;
      ee_pos <= `EE_POS_RESET;
    end else begin
      mode <= next_mode;
      captured <= next_captured;
      map_pos <= next_map_pos;
      ee_pos <= next_ee_pos;
    end
  end
  wire logic bus_mode = (mode == MODE_EXPANDED) || (mode == MODE_TEST);
  assign mode_o = mode;
  assign vector_from_ram_o = (mode == MODE_BOOT);
  logic [11:0] off;
  logic shared_page, hit_reg, hit_ram, hit_ee, hit_boot, hit_rom, rom_on, rom_high;
  always_comb begin
    off = cpu_addr_i[11:0];
    shared_page = map_pos[7:4] == map_pos[3:0];
    hit_reg = on_page(cpu_addr_i, map_pos[3:0]) && off <= `REG_END_OFF;
    hit_ram = 1'b0;
    ram_index_o = off[9:0];
    if (on_page(cpu_addr_i, map_pos[7:4])) begin
      if (shared_page) begin
        hit_ram = off >= `RAM_SHARED_START && off <= `RAM_SHARED_END;
        ram_index_o = 10'(off - `RAM_SHARED_START);
      end else begin
        hit_ram = off <= `RAM_SOLO_END;
      end
    end
    hit_ee = eeprom_enable_i && on_page(cpu_addr_i, ee_pos) && off >= `EE_START_OFF;
    hit_boot = (mode == MODE_BOOT) && cpu_addr_i >= `BOOT_START
      && cpu_addr_i <= `BOOT_END;
    rom_on = rom_enable_bit_i && (mode != MODE_TEST);
    rom_high = (mode == MODE_SINGLE) ? 1'b1 : rom_placement_bit_i;
    hit_rom = rom_on && (cpu_addr_i[15] == rom_high);
    sel_reg_o = cpu_valid_i && hit_reg;
    sel_ram_o = cpu_valid_i && !hit_reg && hit_ram;
    sel_eeprom_o = cpu_valid_i && !hit_reg && !hit_ram && hit_ee;
    sel_boot_o = cpu_valid_i && !hit_reg && !hit_ram && !hit_ee && hit_boot;
    sel_rom_o = cpu_valid_i && !hit_reg && !hit_ram && !hit_ee && !hit_boot && hit_rom;
    sel_ext_o = cpu_valid_i && bus_mode
      && !(hit_reg || hit_ram || hit_ee || hit_boot || hit_rom);
  end
  // Pin state: the expansion bus follows the access by one cycle.
  logic [7:0] next_port_b, next_port_b_oe_n, next_port_f, next_port_f_oe_n;
  logic [7:0] next_port_c, next_port_c_oe_n, next_ext_rdata;
  logic next_dir, next_dir_oe_n;
  always_comb begin
    next_port_b = gpio_b_i;
    next_port_b_oe_n = gpio_b_oe_n_i;
    next_port_f = gpio_f_i;
    next_port_f_oe_n = gpio_f_oe_n_i;
    next_port_c = gpio_c_i;
    next_port_c_oe_n = gpio_c_oe_n_i;
    next_dir = gpio_dir_i;
    next_dir_oe_n = gpio_dir_oe_n_i;
    next_ext_rdata = port_c_i;
    if (bus_mode) begin
      next_port_b = cpu_addr_i[15:8];
      next_port_b_oe_n = 8'h00;
      next_port_f = cpu_addr_i[7:0];
      next_port_f_oe_n = 8'h00;
      next_port_c = cpu_wdata_i;
      // Data lines are released on reads so the external part can drive them.
      next_port_c_oe_n = (sel_ext_o && !cpu_rw_i) ? 8'h00 : 8'hff;
      next_dir = sel_ext_o ? cpu_rw_i : 1'b1;
      next_dir_oe_n = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_b_o <= 8'h00;
      port_b_oe_n_o <= 8'hff;
      port_f_o <= 8'h00;
      port_f_oe_n_o <= 8'hff;
      port_c_o <= 8'h00;
      port_c_oe_n_o <= 8'hff;
      shared_direction_pin_o <= 1'b1;
      shared_direction_pin_oe_n_o <= 1'b1;
      ext_rdata_o <= 8'h00;
    end else begin
      port_b_o <= next_port_b;
      port_b_oe_n_o <= next_port_b_oe_n;
      port_f_o <= next_port_f;
      port_f_oe_n_o <= next_port_f_oe_n;
      port_c_o <= next_port_c;
      port_c_oe_n_o <= next_port_c_oe_n;
      shared_direction_pin_o <= next_dir;
      shared_direction_pin_oe_n_o <= next_dir_oe_n;
      ext_rdata_o <= next_ext_rdata;
    end
  end
  loader_t ld, next_ld;
  logic [10:0] count, next_count;
  logic [7:0] idle, next_idle, tout, next_tout;
  logic [1:0] next_baud;
  logic next_tx_valid, next_load_wr, next_jump;
  logic [7:0] next_tx_data;
  logic [15:0] next_load_addr;
  always_comb begin
    next_ld = ld;
    next_count = count;
    next_idle = idle;
    next_tout = tout;
    next_baud = baud_sel_o;
    next_tx_valid = 1'b0;
    next_tx_data = tx_data_o;
    next_load_wr = 1'b0;
    next_load_addr = load_addr_o;
    next_jump = 1'b0;
    unique case (ld)
      LD_OFF: next_ld = (captured && mode == MODE_BOOT) ? LD_SYNC : LD_OFF;
      LD_SYNC: begin
        if (rx_valid_i) begin
          // Unknown sync values fall back to the all-ones rate and timeout.
          unique case (rx_data_i)
            `SYNC_F0: begin
              next_baud = `BAUD_F0;
              next_tout = `TOUT_F0;
            end
            `SYNC_FD: begin
              next_baud = `BAUD_FD;
              next_tout = `TOUT_FD;
            end
            default: begin
              next_baud = `BAUD_FF;
              next_tout = `TOUT_FF;
            end
          endcase
          next_idle = 8'h00;
          next_ld = LD_LOAD;
        end
      end
      LD_LOAD: begin
        if (rx_valid_i) begin
          next_load_wr = 1'b1;
          next_load_addr = `LOAD_BASE + 16'(count);
          next_tx_valid = 1'b1;
          next_tx_data = rx_data_i;
          next_count = count + 11'h001;
          next_idle = 8'h00;
          if (count == 11'(LOAD_MAX - 1)) begin
            next_ld = LD_DONE;
            next_jump = 1'b1;
          end
        end else if (char_tenth_tick_i) begin
          next_idle = idle + 8'h01;
          if (idle + 8'h01 >= tout) begin
            next_ld = LD_DONE;
            next_jump = 1'b1;
          end
        end
      end
      LD_DONE: next_ld = LD_DONE;
      default: next_ld = LD_OFF;
    endcase
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ld <= LD_OFF;
      count <= 11'h000;
      idle <= 8'h00;
      tout <= `TOUT_FF;
      baud_sel_o <= `BAUD_FF;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      load_wr_o <= 1'b0;
      load_addr_o <= `LOAD_BASE;
      load_data_o <= 8'h00;
      jump_valid_o <= 1'b0;
    end else begin
      ld <= next_ld;
      count <= next_count;
      idle <= next_idle;
      tout <= next_tout;
      baud_sel_o <= next_baud;
      tx_valid_o <= next_tx_valid;
      tx_data_o <= next_tx_data;
      load_wr_o <= next_load_wr;
      load_addr_o <= next_load_addr;
      load_data_o <= next_tx_data;
      jump_valid_o <= next_jump;
    end
  end
  assign jump_addr_o = `LOAD_BASE;
  assign portd_open_drain_o = (ld == LD_SYNC) || (ld == LD_LOAD);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_mode_stable: assert property (captured |=> $stable(mode))
    else $error("mode changed after capture");
  chk_single_gpio: assert property (mode == MODE_SINGLE |=>
    port_b_oe_n_o == $past(gpio_b_oe_n_i) && !sel_ext_o)
    else $error("single chip mode drove the bus");
  chk_addr_pins: assert property (bus_mode && cpu_valid_i |=>
    port_b_o == $past(cpu_addr_i[15:8]) && port_f_o == $past(cpu_addr_i[7:0]))
    else $error("address pins do not follow the access");
  chk_dir_pin: assert property (sel_ext_o |=>
    shared_direction_pin_o == $past(cpu_rw_i)
    && port_c_oe_n_o == ($past(cpu_rw_i) ? 8'hff : 8'h00))
    else $error("direction pin or data enable wrong");
  chk_boot_window: assert property (sel_boot_o |->
    mode == MODE_BOOT && cpu_addr_i[15:9] == 7'h5f && cpu_addr_i[8:0] >= 9'h040)
    else $error("boot ROM selected outside bootstrap window");
  chk_echo_store: assert property (ld == LD_LOAD && rx_valid_i |=>
    tx_valid_o && load_wr_o && tx_data_o == $past(rx_data_i)
    && load_addr_o == 16'h0080 + 16'($past(count)))
    else $error("download byte not echoed or stored");
  chk_jump_end: assert property (jump_valid_o |-> ld == LD_DONE
    && jump_addr_o == 16'h0080 && $past(ld) == LD_LOAD)
    else $error("jump without a finished download");
  chk_test_norom: assert property (mode == MODE_TEST |-> !sel_rom_o)
    else $error("main ROM decoded in test mode");
  chk_reg_first: assert property (sel_reg_o |->
    !sel_ram_o && !sel_eeprom_o && !sel_rom_o && !sel_ext_o)
    else $error("two resources selected");
  chk_single_rom: assert property (sel_rom_o && mode == MODE_SINGLE |-> cpu_addr_i[15])
    else $error("single chip ROM outside upper half");

  cov_download: cover property (ld == LD_LOAD ##1 jump_valid_o);
  cov_ext_write: cover property (sel_ext_o && !cpu_rw_i);
  cov_ram_remap: cover property (sel_ram_o && off >= 12'h400 && off <= 12'h47f);
  cov_sync_fd: cover property (ld == LD_SYNC && rx_valid_i && rx_data_i == 8'hfd);

endmodule // mode_map_decoder

// ### shared/mode_map_defines.svh
// Constants for the mode selection and memory map decoder.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef MODE_MAP_DEFINES_SVH
`define MODE_MAP_DEFINES_SVH
// Strap codes on {mode_pin_b, mode_pin_a}.
`define STRAP_BOOT 2'h0
`define STRAP_TEST 2'h1
`define STRAP_SINGLE 2'h2
`define STRAP_EXPANDED 2'h3
// Offsets inside a 4 KB page.
`define REG_END_OFF 12'h07f
`define RAM_SHARED_START 12'h080
`define RAM_SHARED_END 12'h47f
`define RAM_SOLO_END 12'h3ff
`define EE_START_OFF 12'hd80
// Absolute addresses.
`define BOOT_START 16'hbe40
`define BOOT_END 16'hbfff
`define LOAD_BASE 16'h0080
// Reset values of the position registers.
`define MAP_POS_RESET 8'h00
`define EE_POS_RESET 4'h0
// Sync bytes and idle timeouts in tenths of a character time.
`define SYNC_FF 8'hff
`define SYNC_F0 8'hf0
`define SYNC_FD 8'hfd
`define TOUT_FF 8'h28
`define TOUT_F0 8'h31
`define TOUT_FD 8'had
`define BAUD_FF 2'h0
`define BAUD_F0 2'h1
`define BAUD_FD 2'h2
`endif

// ### shared/mode_map_pkg.sv
// Types shared by the mode selection and memory map decoder.
// Assumes no defines header; the enum values are written out in this file.
package mode_map_pkg;
  typedef enum logic [3:0] {
    MODE_SINGLE = 4'h1,
    MODE_EXPANDED = 4'h2,
    MODE_BOOT = 4'h4,
    MODE_TEST = 4'h8
  } mode_t;
  typedef enum logic [3:0] {
    LD_OFF = 4'h1,
    LD_SYNC = 4'h2,
    LD_LOAD = 4'h4,
    LD_DONE = 4'h8
  } loader_t;
endpackage

// ### test/ext_bus_model.sv
// External memory on the expansion bus, indexed by the low address byte.
// Assumes the decoder's registered bus pins and data sampled one cycle after the address.
`timescale 1ns/1ps
module ext_bus_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] bus_lo_i,
  input wire logic [7:0] bus_data_i,
  input wire logic [7:0] bus_oe_n_i,
  input wire logic bus_dir_i,
  output logic [7:0] bus_rd_o
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic rd;
  // Only drive the data bus while the device reads and has let go of it.
  assign rd = bus_dir_i && (bus_oe_n_i == 8'hff);
  // The data bus has no pull-up, so an idle bus must never look like the old value.
  assign bus_rd_o = rd ? mem[bus_lo_i] : ~last;
  always @(posedge sys_clk_i) begin
    last <= bus_rd_o;
    if (!bus_dir_i && bus_oe_n_i == 8'h00) begin
      mem[bus_lo_i] <= bus_data_i;
    end
  end
endmodule // ext_bus_model

// ### test/test_mode_map_decoder.sv
// Self-checking bench for mode latch, memory decode, bus pins and boot download.
// Assumes the shared package, the defines header and the expansion bus model.
`timescale 1ns/1ps
`include "mode_map_defines.svh"
module test_mode_map_decoder import mode_map_pkg::*;;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, mode_pin_a_i = 1'b0, mode_pin_b_i = 1'b0;
  logic rom_enable_bit_i = 1'b1, rom_placement_bit_i = 1'b0, eeprom_enable_i = 1'b1;
  logic map_pos_wr_i = 1'b0, eeprom_pos_wr_i = 1'b0, cpu_valid_i = 1'b0, cpu_rw_i = 1'b1;
  logic [7:0] map_pos_i = 8'h00, cpu_wdata_i = 8'h00, rx_data_i = 8'h00;
  logic [3:0] eeprom_pos_i = 4'h0;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [7:0] gpio_b_i = 8'h11, gpio_b_oe_n_i = 8'h0f, gpio_f_i = 8'h22, gpio_f_oe_n_i = 8'hf0;
  logic [7:0] gpio_c_i = 8'h33, gpio_c_oe_n_i = 8'h55;
  logic gpio_dir_i = 1'b0, gpio_dir_oe_n_i = 1'b0, rx_valid_i = 1'b0, char_tenth_tick_i = 1'b0;
  logic [7:0] ext_rdata_o, port_b_o, port_b_oe_n_o, port_f_o, port_f_oe_n_o, port_c_i;
  logic [7:0] port_c_o, port_c_oe_n_o, tx_data_o, load_data_o;
  logic sel_reg_o, sel_ram_o, sel_eeprom_o, sel_boot_o, sel_rom_o, sel_ext_o;
  logic vector_from_ram_o, portd_open_drain_o, shared_direction_pin_o;
  logic shared_direction_pin_oe_n_o, tx_valid_o, load_wr_o, jump_valid_o;
  logic [9:0] ram_index_o;
  logic [3:0] mode_o;
  logic [1:0] baud_sel_o;
  logic [15:0] load_addr_o, jump_addr_o;
  int n_fail = 0, cmp_count = 0, cycles = 0;
  logic saw_jump = 1'b0;
  logic [3:0] mode_tab [4] = '{MODE_BOOT, MODE_TEST, MODE_SINGLE, MODE_EXPANDED};
  logic [7:0] sync_tab [3] = '{`SYNC_FF, `SYNC_F0, `SYNC_FD};
  logic [1:0] baud_tab [3] = '{`BAUD_FF, `BAUD_F0, `BAUD_FD};
  int tout_tab [3] = '{`TOUT_FF, `TOUT_F0, `TOUT_FD};

  mode_map_decoder #(.LOAD_MAX(4)) i_mode_map_decoder (
    .sys_clk_i, .sys_rst_i, .mode_pin_a_i, .mode_pin_b_i, .rom_enable_bit_i,
    .rom_placement_bit_i, .eeprom_enable_i, .map_pos_wr_i, .map_pos_i, .eeprom_pos_wr_i,
    .eeprom_pos_i, .cpu_valid_i, .cpu_addr_i, .cpu_rw_i, .cpu_wdata_i, .ext_rdata_o,
    .sel_reg_o, .sel_ram_o, .ram_index_o, .sel_eeprom_o, .sel_boot_o, .sel_rom_o, .sel_ext_o,
    .mode_o, .vector_from_ram_o, .portd_open_drain_o, .gpio_b_i, .gpio_b_oe_n_i, .gpio_f_i,
    .gpio_f_oe_n_i, .gpio_c_i, .gpio_c_oe_n_i, .gpio_dir_i, .gpio_dir_oe_n_i, .port_b_o,
    .port_b_oe_n_o, .port_f_o, .port_f_oe_n_o, .port_c_i, .port_c_o, .port_c_oe_n_o,
    .shared_direction_pin_o, .shared_direction_pin_oe_n_o, .rx_valid_i, .rx_data_i,
    .char_tenth_tick_i, .baud_sel_o, .tx_valid_o, .tx_data_o, .load_wr_o, .load_addr_o,
    .load_data_o, .jump_valid_o, .jump_addr_o
  );
  ext_bus_model i_ext_bus_model (
    .sys_clk_i(sys_clk_i), .bus_lo_i(port_f_o), .bus_data_i(port_c_o),
    .bus_oe_n_i(port_c_oe_n_o), .bus_dir_i(shared_direction_pin_o), .bus_rd_o(port_c_i)
  );

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (jump_valid_o === 1'b1) begin
      saw_jump = 1'b1;
    end
    if (cycles == 6000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic restart(input logic [1:0] strap);
    cpu_valid_i = 1'b0;
    sys_rst_i = 1'b1;
    {mode_pin_b_i, mode_pin_a_i} = strap;
    step(16);
    check("reset_oe_n", {port_b_oe_n_o, port_c_oe_n_o}, 16'hffff);
    sys_rst_i = 1'b0;
    step(2);
    check("mode", mode_o, mode_tab[strap]);
    check("vector_ram", vector_from_ram_o, strap == `STRAP_BOOT);
  endtask

  task automatic dec(input logic [15:0] a, input logic [5:0] exp);
    step();
    cpu_addr_i = a;
    cpu_valid_i = 1'b1;
    #1;
    check("sel", {sel_reg_o, sel_ram_o, sel_eeprom_o, sel_boot_o, sel_rom_o, sel_ext_o}, exp);
  endtask

  task automatic ram(input logic [15:0] a, input logic [9:0] idx);
    dec(a, 6'b010000);
    check("ram_index", ram_index_o, idx);
  endtask

  task automatic wpos(input logic [7:0] m, input logic [3:0] e);
    step();
    {map_pos_i, eeprom_pos_i, map_pos_wr_i, eeprom_pos_wr_i} = {m, e, 2'b11};
    step();
    {map_pos_wr_i, eeprom_pos_wr_i} = 2'b00;
  endtask

  task automatic send(input logic [7:0] b);
    step();
    rx_data_i = b;
    rx_valid_i = 1'b1;
    step();
    rx_valid_i = 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      step();
      char_tenth_tick_i = 1'b1;
      step();
      char_tenth_tick_i = 1'b0;
    end
  endtask

  initial begin
    restart(`STRAP_EXPANDED);
    dec(16'h0010, 6'b100000);
    ram(16'h0080, 10'h000);
    ram(16'h0400, 10'h380);
    ram(16'h047f, 10'h3ff);
    dec(16'h0480, 6'b000010);
    dec(16'h0d80, 6'b001000);
    dec(16'h7fff, 6'b000010);
    dec(16'h8000, 6'b000001);
    dec(16'hbe40, 6'b000001);
    wpos(8'h10, 4'h0);
    ram(16'h1000, 10'h000);
    ram(16'h13ff, 10'h3ff);
    dec(16'h0080, 6'b000010);
    dec(16'h0000, 6'b100000);
    wpos(8'h13, 4'h2);
    dec(16'h3000, 6'b100000);
    dec(16'h0000, 6'b000010);
    dec(16'h2d80, 6'b001000);
    eeprom_enable_i = 1'b0;
    dec(16'h2d80, 6'b000010);
    rom_enable_bit_i = 1'b0;
    dec(16'h7fff, 6'b000001);
    $display("decode test done");
    cpu_rw_i = 1'b0;
    cpu_wdata_i = 8'hc3;
    dec(16'h9a5c, 6'b000001);
    step();
    check("bus_addr", {port_b_o, port_f_o}, 16'h9a5c);
    check("bus_data", {port_c_oe_n_o, port_c_o}, 16'h00c3);
    check("bus_dir", shared_direction_pin_o, 1'b0);
    cpu_rw_i = 1'b1;
    step();
    check("bus_read", {shared_direction_pin_o, port_c_oe_n_o}, 9'h1ff);
    cpu_valid_i = 1'b0;
    step();
    check("ext_rdata", ext_rdata_o, 8'hc3);
    $display("expansion bus test done");
    rom_enable_bit_i = 1'b1;
    restart(`STRAP_SINGLE);
    dec(16'h9a5c, 6'b000010);
    step();
    check("port_b", {port_b_oe_n_o, port_b_o}, {gpio_b_oe_n_i, gpio_b_i});
    check("port_f", {port_f_oe_n_o, port_f_o}, {gpio_f_oe_n_i, gpio_f_i});
    check("port_c", {port_c_oe_n_o, port_c_o}, {gpio_c_oe_n_i, gpio_c_i});
    check("dir_pin", {shared_direction_pin_oe_n_o, shared_direction_pin_o}, 2'b00);
    dec(16'h8000, 6'b000010);
    dec(16'hffff, 6'b000010);
    dec(16'h7fff, 6'b000000);
    rom_placement_bit_i = 1'b1;
    restart(`STRAP_TEST);
    dec(16'h8000, 6'b000001);
    rom_placement_bit_i = 1'b0;
    $display("mode pin test done");
    restart(`STRAP_BOOT);
    dec(16'hbe40, 6'b000100);
    dec(16'hbfff, 6'b000100);
    dec(16'hc000, 6'b000000);
    check("open_drain", portd_open_drain_o, 1'b1);
    send(8'hff);
    check("baud", baud_sel_o, `BAUD_FF);
    for (int i = 0; i < 4; i++) begin
      send({4'ha, i[3:0]});
      check("tx", {tx_valid_o, tx_data_o}, {1'b1, 4'ha, i[3:0]});
      check("load", {load_wr_o, load_data_o}, {1'b1, 4'ha, i[3:0]});
      check("load_addr", load_addr_o, `LOAD_BASE + i[15:0]);
    end
    step(3);
    check("jump", {saw_jump, jump_addr_o}, {1'b1, `LOAD_BASE});
    check("open_drain", portd_open_drain_o, 1'b0);
    send(8'h77);
    check("tx_after_done", tx_valid_o, 1'b0);
    $display("download count test done");
    for (int k = 0; k < 3; k++) begin
      restart(`STRAP_BOOT);
      send(sync_tab[k]);
      check("baud", baud_sel_o, baud_tab[k]);
      send(8'h5a);
      saw_jump = 1'b0;
      ticks(tout_tab[k] - 1);
      check("early_jump", saw_jump, 1'b0);
      ticks(3);
      check("idle_jump", saw_jump, 1'b1);
    end
    $display("download timeout test done");
    tally_and_finish();
  end
endmodule // test_mode_map_decoder
